// ---- rtl/dsos_pkg.sv ----
// Shared constants for the drive status output selector.
package dsos_pkg;

    // Clock and control-cycle timing.
    localparam int CLK_PERIOD_NS  = 50;
    localparam int CTRL_PERIOD_NS = 1000;
    localparam int CTRL_DIV       = (CTRL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Widths and counts.
    localparam int DATA_W    = 16;
    localparam int OPT_W     = 6;
    localparam int NUM_FLAGS = 13;
    localparam int NUM_TERM  = 3;
    localparam int WDT_W     = 16;

    // Option codes handled by this block; code 21 maps to flag 0.
    localparam logic [OPT_W-1:0] OPT_FIRST = 6'h15;
    localparam logic [OPT_W-1:0] OPT_LAST  = 6'h21;

    // Flag positions, one per option code from 21 upward.
    localparam int FLAG_ZERO_SPEED = 0;
    localparam int FLAG_SPEED_DEV  = 1;
    localparam int FLAG_POS_DONE   = 2;
    localparam int FLAG_OVER_FREQ  = 3;
    localparam int FLAG_AT_FREQ    = 4;
    localparam int FLAG_OVERLOAD2  = 5;
    localparam int FLAG_VOLT_LOSS  = 6;
    localparam int FLAG_CURR_LOSS  = 7;
    localparam int FLAG_FEEDBACK   = 10;
    localparam int FLAG_LINK_LOSS  = 11;
    localparam int FLAG_BOOL_ONE   = 12;

    // Boolean operators for the logic output.
    localparam logic [1:0] BOOL_AND = 2'h0;
    localparam logic [1:0] BOOL_OR  = 2'h1;
    localparam logic [1:0] BOOL_XOR = 2'h2;

    // Register byte offsets.
    localparam logic [7:0] OFS_TERM_SEL  = 8'h00;
    localparam logic [7:0] OFS_ZS_THR    = 8'h04;
    localparam logic [7:0] OFS_DEV_LIM   = 8'h08;
    localparam logic [7:0] OFS_OL2_THR   = 8'h0C;
    localparam logic [7:0] OFS_VLOSS_THR = 8'h10;
    localparam logic [7:0] OFS_ILOSS_THR = 8'h14;
    localparam logic [7:0] OFS_FB_LOW    = 8'h18;
    localparam logic [7:0] OFS_FB_HIGH   = 8'h1C;
    localparam logic [7:0] OFS_WDT_PER   = 8'h20;
    localparam logic [7:0] OFS_BOOL_CFG  = 8'h24;
    localparam logic [7:0] OFS_FLAGS     = 8'h28;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h2C;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h30;
    localparam logic [7:0] OFS_TERM_OUT  = 8'h34;

    // Values after reset.
    localparam logic [17:0] RST_TERM_SEL  = 18'h00000;
    localparam logic [15:0] RST_THR       = 16'h0000;
    localparam logic [15:0] RST_WDT_PER   = 16'h0000;
    localparam logic [9:0]  RST_BOOL_CFG  = 10'h000;

endpackage

// ---- rtl/dsos_flag_if.sv ----
// Flag vector and control tick passed from the evaluator to the terminal selectors.
interface dsos_flag_if #(
    parameter int N = 13
);
    logic [N-1:0] flags;
    logic         tick;

    modport drive (output flags, output tick);
    modport sel   (input flags, input tick);
endinterface

// ---- rtl/dsos_term_mux.sv ----
// One output terminal: picks the flag named by its option code each control cycle.
module dsos_term_mux
    import dsos_pkg::*;
(
    // Clock and reset.
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    // Flags from the evaluator.
    dsos_flag_if.sel                        flg,
    // Option code and terminal level.
    input  wire logic [dsos_pkg::OPT_W-1:0] opt_code,
    output logic                            term
);
    import dsos_pkg::*;

    // Codes outside the handled range leave the terminal inactive.
    function automatic logic flag_of(input logic [OPT_W-1:0] code,
                                     input logic [NUM_FLAGS-1:0] f);
        logic [OPT_W-1:0] idx;
        idx = code - OPT_FIRST;
        if (code < OPT_FIRST || code > OPT_LAST) begin
            return 1'b0;
        end
        return f[idx[3:0]];
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            term <= 1'b0;
        end else if (flg.tick) begin
            term <= flag_of(opt_code, flg.flags); // [R1] [R14]
        end
    end

    chk_unused_code_off: assert property (@(posedge hclk) disable iff (!hresetn) // [R14]
        flg.tick && (opt_code < OPT_FIRST || opt_code > OPT_LAST) |=> !term)
        else $error("terminal active for an unhandled option code");

    chk_term_follows: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
        flg.tick |=> term == $past(flag_of(opt_code, flg.flags)))
        else $error("terminal does not show its selected flag");

endmodule

// ---- rtl/dsos_top.sv ----
// Status flag generator and terminal selector for option codes 21 to 33.
// Operation
// R1: Several output terminals each show the flag chosen by their own option code.
// R2: Code 21: on while output frequency is below the zero-speed threshold.
// R3: Code 22: on while speed command and actual speed differ beyond limit.
// R4: Code 23: on once positioning has finished, off otherwise.
// R5: Code 24: on while running at or above set frequency, ramps included.
// R6: Code 25: on while running exactly at set frequency, ramps included.
// R7: Code 26: on while output current exceeds the second overload threshold.
// R8: Code 27: on while analog voltage input is below its loss threshold.
// R9: Code 28: on while analog current input is below its loss threshold.
// R10: Code 31: set while running and process variable is below the low limit.
// R11: Code 31 cleared above high limit or on run-to-stop; holds otherwise.
// R12: Code 32: on once the communications watchdog expires; activity keeps it off.
// R13: Code 33: follows the configured Boolean operation result.
// R14: Flags refresh every control cycle; unhandled codes leave terminals inactive.
module dsos_top
    import dsos_pkg::*;
#(
    parameter int DW    = dsos_pkg::DATA_W,
    parameter int NTERM = dsos_pkg::NUM_TERM
) (
    // Clock and reset.
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // AHB-Lite slave.
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [31:0]       hwdata,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // Measurements from the drive.
    input  wire logic              running,
    input  wire logic [DW-1:0]     out_freq,
    input  wire logic [DW-1:0]     set_freq,
    input  wire logic [DW-1:0]     speed_cmd,
    input  wire logic [DW-1:0]     speed_act,
    input  wire logic [DW-1:0]     out_current,
    input  wire logic [DW-1:0]     ain_voltage,
    input  wire logic [DW-1:0]     ain_current,
    input  wire logic [DW-1:0]     process_variable,
    input  wire logic              pos_finished,
    input  wire logic              comm_activity,
    // Terminals and interrupt.
    output logic [NTERM-1:0]       term_out,
    output logic                   irq
);
    import dsos_pkg::*;

    dsos_flag_if #(.N(NUM_FLAGS)) flg ();

    // Configuration registers.
    logic [NTERM*OPT_W-1:0] term_sel;
    logic [DW-1:0]          zs_thr;
    logic [DW-1:0]          dev_lim;
    logic [DW-1:0]          ol2_thr;
    logic [DW-1:0]          vloss_thr;
    logic [DW-1:0]          iloss_thr;
    logic [DW-1:0]          fb_low;
    logic [DW-1:0]          fb_high;
    logic [WDT_W-1:0]       wdt_period;
    logic [9:0]             bool_cfg;
    logic [NUM_FLAGS-1:0]   irq_status;
    logic [NUM_FLAGS-1:0]   irq_mask;

    // Internal state.
    logic [NUM_FLAGS-1:0]   flags;
    logic [NUM_FLAGS-1:0]   flags_prev;
    logic [NTERM-1:0]       term_q;
    logic [4:0]             div_cnt;
    logic                   tick;
    logic [WDT_W-1:0]       wdt_cnt;
    logic                   run_prev;
    logic                   wr_pend;
    logic [7:0]             wr_addr;
    logic [DW-1:0]          speed_diff;
    logic                   bool_a;
    logic                   bool_b;
    logic                   next_bool;
    logic                   next_fb;
    logic                   ahb_take;

    assign flg.flags = flags;
    assign flg.tick  = tick;

    // Control-cycle divider; every flag moves only on this enable, except the link-loss flag, which activity clears at once.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt <= 5'h00;
            tick    <= 1'b0;
        end else if (div_cnt == 5'(CTRL_DIV - 1)) begin
            div_cnt <= 5'h00;
            tick    <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 5'h01;
            tick    <= 1'b0;
        end
    end

    // AHB-Lite: zero wait states, OKAY only; reads are sampled in the address phase.
    assign ahb_take = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready) begin
                wr_pend <= ahb_take && hwrite;
                wr_addr <= haddr[7:0];
            end
        end
    end

    function automatic logic [31:0] reg_read(input logic [7:0] a);
        case (a)
            OFS_TERM_SEL:  reg_read = 32'(term_sel);
            OFS_ZS_THR:    reg_read = 32'(zs_thr);
            OFS_DEV_LIM:   reg_read = 32'(dev_lim);
            OFS_OL2_THR:   reg_read = 32'(ol2_thr);
            OFS_VLOSS_THR: reg_read = 32'(vloss_thr);
            OFS_ILOSS_THR: reg_read = 32'(iloss_thr);
            OFS_FB_LOW:    reg_read = 32'(fb_low);
            OFS_FB_HIGH:   reg_read = 32'(fb_high);
            OFS_WDT_PER:   reg_read = 32'(wdt_period);
            OFS_BOOL_CFG:  reg_read = 32'(bool_cfg);
            OFS_FLAGS:     reg_read = 32'(flags);
            OFS_IRQ_STAT:  reg_read = 32'(irq_status);
            OFS_IRQ_MASK:  reg_read = 32'(irq_mask);
            OFS_TERM_OUT:  reg_read = 32'(term_q);
            default:       reg_read = 32'h00000000;
        endcase
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (ahb_take && !hwrite) begin
            hrdata <= reg_read(haddr[7:0]);
        end
    end

    // Writable configuration; unmapped writes are dropped silently.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            term_sel   <= RST_TERM_SEL;
            zs_thr     <= RST_THR;
            dev_lim    <= RST_THR;
            ol2_thr    <= RST_THR;
            vloss_thr  <= RST_THR;
            iloss_thr  <= RST_THR;
            fb_low     <= RST_THR;
            fb_high    <= RST_THR;
            wdt_period <= RST_WDT_PER;
            bool_cfg   <= RST_BOOL_CFG;
            irq_mask   <= 13'h0000;
        end else if (wr_pend) begin
            case (wr_addr)
                OFS_TERM_SEL:  term_sel   <= hwdata[NTERM*OPT_W-1:0];
                OFS_ZS_THR:    zs_thr     <= hwdata[DW-1:0];
                OFS_DEV_LIM:   dev_lim    <= hwdata[DW-1:0];
                OFS_OL2_THR:   ol2_thr    <= hwdata[DW-1:0];
                OFS_VLOSS_THR: vloss_thr  <= hwdata[DW-1:0];
                OFS_ILOSS_THR: iloss_thr  <= hwdata[DW-1:0];
                OFS_FB_LOW:    fb_low     <= hwdata[DW-1:0];
                OFS_FB_HIGH:   fb_high    <= hwdata[DW-1:0];
                OFS_WDT_PER:   wdt_period <= hwdata[WDT_W-1:0];
                OFS_BOOL_CFG:  bool_cfg   <= hwdata[9:0];
                OFS_IRQ_MASK:  irq_mask   <= hwdata[NUM_FLAGS-1:0];
                default:       ;
            endcase
        end
    end

    // Interrupt status: a flag rising sets its bit; a written one clears, set wins.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= 13'h0000;
            irq        <= 1'b0;
        end else begin
            if (wr_pend && wr_addr == OFS_IRQ_STAT) begin
                irq_status <= (irq_status & ~hwdata[NUM_FLAGS-1:0]) | (flags & ~flags_prev);
            end else begin
                irq_status <= irq_status | (flags & ~flags_prev);
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_prev <= 13'h0000;
        end else begin
            flags_prev <= flags;
        end
    end

    // Communications watchdog; a zero period disables it. Activity restarts it at once.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_cnt <= 16'h0000;
        end else if (comm_activity || wdt_period == 16'h0000) begin
            wdt_cnt <= 16'h0000;
        end else if (tick && wdt_cnt < wdt_period) begin
            wdt_cnt <= wdt_cnt + 16'h0001; // [R12]
        end
    end

    // Boolean operands are last cycle's flags, so the logic output cannot loop on itself.
    assign speed_diff = (speed_cmd > speed_act) ? speed_cmd - speed_act : speed_act - speed_cmd;
    assign bool_a     = (bool_cfg[3:0] < 4'(NUM_FLAGS)) ? flags[bool_cfg[3:0]] : 1'b0;
    assign bool_b     = (bool_cfg[7:4] < 4'(NUM_FLAGS)) ? flags[bool_cfg[7:4]] : 1'b0;

    always_comb begin
        case (bool_cfg[9:8])
            BOOL_AND: next_bool = bool_a & bool_b;
            BOOL_OR:  next_bool = bool_a | bool_b;
            BOOL_XOR: next_bool = bool_a ^ bool_b;
            default:  next_bool = 1'b0;
        endcase
    end

    // Level flags, refreshed once per control cycle from the present measurements.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags <= '0;
        end else if (tick) begin // [R14]
            flags[FLAG_ZERO_SPEED] <= out_freq < zs_thr; // [R2]
            flags[FLAG_SPEED_DEV]  <= speed_diff > dev_lim; // [R3]
            flags[FLAG_POS_DONE]   <= pos_finished; // [R4]
            flags[FLAG_OVER_FREQ]  <= running && out_freq != '0 && out_freq >= set_freq; // [R5]
            flags[FLAG_AT_FREQ]    <= running && out_freq != '0 && out_freq == set_freq; // [R6]
            flags[FLAG_OVERLOAD2]  <= out_current > ol2_thr; // [R7]
            flags[FLAG_VOLT_LOSS]  <= ain_voltage < vloss_thr; // [R8]
            flags[FLAG_CURR_LOSS]  <= ain_current < iloss_thr; // [R9]
            flags[9:8]             <= 2'h0;
            flags[FLAG_FEEDBACK]   <= next_fb; // [R10] [R11]
            flags[FLAG_LINK_LOSS]  <= !comm_activity && wdt_period != 16'h0000
                                      && wdt_cnt >= wdt_period; // [R12]
            flags[FLAG_BOOL_ONE]   <= next_bool; // [R13]
        end else if (comm_activity) begin
            flags[FLAG_LINK_LOSS] <= 1'b0; // [R12]
        end
    end

    // Second-stage feedback: set/reset latch; clearing wins if both occur together.
    // The latch state lives in the flag word so that one process owns every flag bit.
    always_comb begin
        next_fb = flags[FLAG_FEEDBACK];
        if (process_variable > fb_high || (run_prev && !running)) begin
            next_fb = 1'b0; // [R11]
        end else if (running && process_variable < fb_low) begin
            next_fb = 1'b1; // [R10]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_prev <= 1'b0;
        end else if (tick) begin
            run_prev <= running;
        end
    end

    // One selector per terminal, each with its own option code.
    for (genvar t = 0; t < NTERM; t++) begin : g_term
        dsos_term_mux u_mux (
            .hclk     (hclk),
            .hresetn  (hresetn),
            .flg      (flg),
            .opt_code (term_sel[t*OPT_W +: OPT_W]),
            .term     (term_q[t])
        ); // [R1]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            term_out <= '0;
        end else begin
            term_out <= term_q;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_zero_speed_cmp: assert property ( // [R2]
        tick |=> flags[FLAG_ZERO_SPEED] == $past(out_freq < zs_thr))
        else $error("zero speed flag wrong");

    chk_speed_dev_cmp: assert property ( // [R3]
        tick |=> flags[FLAG_SPEED_DEV] == $past(speed_diff > dev_lim))
        else $error("speed deviation flag wrong");

    chk_pos_done_flag: assert property ( // [R4]
        tick ##1 !tick [*3] |-> flags[FLAG_POS_DONE] == $past(pos_finished, 3))
        else $error("positioning flag does not follow its input");

    chk_over_freq_stop: assert property ( // [R5]
        tick && !running |=> !flags[FLAG_OVER_FREQ] && !flags[FLAG_AT_FREQ])
        else $error("arrival flag on while stopped");

    chk_at_freq_eq: assert property ( // [R6]
        tick && running && out_freq == set_freq && out_freq != '0 |=> flags[FLAG_AT_FREQ])
        else $error("at-frequency flag missing");

    chk_overload_two: assert property ( // [R7]
        tick |=> flags[FLAG_OVERLOAD2] == $past(out_current > ol2_thr))
        else $error("overload notice wrong");

    chk_input_loss: assert property ( // [R8]
        tick |=> flags[FLAG_VOLT_LOSS] == $past(ain_voltage < vloss_thr))
        else $error("voltage loss flag wrong");

    chk_current_loss: assert property ( // [R9]
        tick |=> flags[FLAG_CURR_LOSS] == $past(ain_current < iloss_thr))
        else $error("current loss flag wrong");

    chk_feedback_set: assert property ( // [R10]
        tick && running && process_variable < fb_low && process_variable <= fb_high
        && !(run_prev && !running) |=> flags[FLAG_FEEDBACK])
        else $error("feedback output not set");

    chk_feedback_stop: assert property ( // [R11]
        tick && run_prev && !running |=> !flags[FLAG_FEEDBACK])
        else $error("feedback output kept after stop");

    chk_link_activity: assert property ( // [R12]
        comm_activity |=> !flags[FLAG_LINK_LOSS] && wdt_cnt == 16'h0000)
        else $error("link loss not cleared by activity");

    chk_bool_result: assert property ( // [R13]
        tick |=> flags[FLAG_BOOL_ONE] == $past(next_bool))
        else $error("logic output does not follow its operation");

    chk_tick_spacing: assert property ( // [R14]
        tick |=> !tick [*8])
        else $error("control ticks too close");

endmodule

// ---- tb/dsos_relay_bank.sv ----
// Relay bank model that reads the output terminals.
module dsos_relay_bank #(
    parameter int N = 3
) (
    // Clock and reset.
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // Terminal levels and contact states.
    input  wire logic [N-1:0] term,
    output logic      [N-1:0] contact
);
    timeunit 1ns;
    timeprecision 1ns;

    // Each contact follows its own terminal one clock later, with no filtering.
    // A glitch on a terminal therefore shows up as contact bounce.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            contact <= '0;
        end else begin
            contact <= term;
        end
    end
endmodule

// ---- tb/tb_drive_status_output_selector.sv ----
// Testbench for the drive status output selector.
module tb_drive_status_output_selector
    import dsos_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [15:0] ZS_T  = 16'h0064;
    localparam logic [15:0] DEV_L = 16'h0032;
    localparam logic [15:0] OL_T  = 16'h00C8;
    localparam logic [15:0] VL_T  = 16'h012C;
    localparam logic [15:0] IL_T  = 16'h0190;

    logic        hclk, hresetn, hsel, hwrite, running, pos_finished, comm_activity;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] out_freq, set_freq, speed_cmd, speed_act, out_current;
    logic [15:0] ain_voltage, ain_current, process_variable;
    logic [7:0]  e8;
    logic [13:0] ex14;
    logic        e;
    wire         hreadyout, hresp, irq;
    wire  [31:0] hrdata;
    wire  [2:0]  term_out, contact;
    int          fails, cmp_count;

    dsos_top dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .running(running),
        .out_freq(out_freq), .set_freq(set_freq), .speed_cmd(speed_cmd),
        .speed_act(speed_act), .out_current(out_current), .ain_voltage(ain_voltage),
        .ain_current(ain_current), .process_variable(process_variable),
        .pos_finished(pos_finished), .comm_activity(comm_activity),
        .term_out(term_out), .irq(irq));

    dsos_relay_bank #(.N(3)) relay (.hclk(hclk), .hresetn(hresetn), .term(term_out),
        .contact(contact));

    always #25 hclk = ~hclk;

    task end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            fails++;
            end_sim();
        end
    endtask

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        check({31'h0, hresp}, 32'h0, "response");
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        ahb(1'b0, a, 32'h0);
        check(rd, exp, msg);
    endtask

    // Logic output lags a flag by one tick, then a mux tick and the relay; 65 cycles covers it.
    task settle();
        repeat (65) @(posedge hclk);
    endtask

    task meas(input logic r, input logic [15:0] of, sf, cm, ac, cu, av, ai, input logic p);
        running      <= r;
        out_freq     <= of;
        set_freq     <= sf;
        speed_cmd    <= cm;
        speed_act    <= ac;
        out_current  <= cu;
        ain_voltage  <= av;
        ain_current  <= ai;
        pos_finished <= p;
    endtask

    task vec(input int v);
        case (v)
        0: meas(1'b0, 16'h0000, 16'h01F4, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b0);
        1: meas(1'b1, 16'h0064, 16'h0064, 16'h0064, 16'h0096, 16'h00C8, 16'h012C, 16'h0190, 1'b1);
        2: meas(1'b1, 16'h0063, 16'h0078, 16'h00C8, 16'h0095, 16'h00C9, 16'h012B, 16'h018F, 1'b0);
        3: meas(1'b1, 16'h0082, 16'h0078, 16'h000A, 16'h003D, 16'h0000, 16'h03E8, 16'h03E8, 1'b0);
        default: meas(1'b0, 16'h0078, 16'h0078, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b0);
        endcase
    endtask

    function automatic logic [7:0] calc8();
        logic [15:0] d;
        d = (speed_cmd > speed_act) ? speed_cmd - speed_act : speed_act - speed_cmd;
        return {ain_current < IL_T, ain_voltage < VL_T, out_current > OL_T,
                running && out_freq != 16'h0000 && out_freq == set_freq,
                running && out_freq != 16'h0000 && out_freq >= set_freq,
                pos_finished, d > DEV_L, out_freq < ZS_T};
    endfunction

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        process_variable = 16'h0000;
        comm_activity = 1'b0;
        fails = 0;
        cmp_count = 0;
        meas(1'b0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0);
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        check({28'h0, irq, term_out}, 32'h0, "outputs in reset");
        wr_all();
        for (int v = 0; v < 5; v++) begin
            vec(v);
            settle();
            e8 = calc8();
            rdchk(OFS_FLAGS, {19'h0, e8[0], 4'h0, e8}, "flag word");
        end
        vec(2);
        settle();
        e8 = calc8();
        ex14 = {1'b0, e8[0], 4'h0, e8};
        for (int c = 0; c < 14; c++) begin
            ahb(1'b1, OFS_TERM_SEL, {14'h0000, 6'(34 - c), 6'h1D, 6'(21 + c)});
            settle();
            check({29'h0, contact}, {29'h0, ex14[13-c], 1'b0, ex14[c]}, "terminal");
        end
        ahb(1'b1, OFS_FB_LOW, 32'h00000032);
        ahb(1'b1, OFS_FB_HIGH, 32'h000001F4);
        ahb(1'b1, OFS_TERM_SEL, {14'h0000, 6'h21, 6'h20, 6'h1F});
        for (int i = 0; i < 6; i++) begin
            running <= (i != 5);
            process_variable <= (i == 1 || i == 3) ? 16'h012C : (i == 2) ? 16'h0258 : 16'h0028;
            settle();
            check({31'h0, contact[0]}, {31'h0, i != 2 && i != 3 && i != 5}, "feedback");
        end
        vec(2);
        for (int op = 0; op < 4; op++) begin
            ahb(1'b1, OFS_BOOL_CFG, {22'h0, 2'(op), 4'h2, 4'h0});
            for (int p = 0; p < 2; p++) begin
                pos_finished <= p[0];
                settle();
                e = (op == 0) ? p[0] : (op == 1) ? 1'b1 : (op == 2) ? !p[0] : 1'b0;
                check({31'h0, contact[2]}, {31'h0, e}, "boolean output");
            end
        end
        ahb(1'b1, OFS_WDT_PER, 32'h00000003);
        repeat (12) begin
            comm_activity <= 1'b1;
            @(posedge hclk);
            comm_activity <= 1'b0;
            repeat (9) @(posedge hclk);
        end
        check({31'h0, contact[1]}, 32'h0, "link kept alive");
        repeat (130) @(posedge hclk);
        check({31'h0, contact[1]}, 32'h1, "link lost");
        comm_activity <= 1'b1;
        @(posedge hclk);
        comm_activity <= 1'b0;
        ahb(1'b0, OFS_FLAGS, 32'h0);
        check({31'h0, rd[11]}, 32'h0, "link restored");
        out_freq <= 16'h0200;
        settle();
        ahb(1'b1, OFS_IRQ_STAT, 32'hFFFFFFFF);
        ahb(1'b0, OFS_IRQ_STAT, 32'h0);
        check({31'h0, rd[0]}, 32'h0, "status cleared");
        out_freq <= 16'h0063;
        settle();
        ahb(1'b0, OFS_IRQ_STAT, 32'h0);
        check({30'h0, irq, rd[0]}, 32'h1, "masked event");
        ahb(1'b1, OFS_IRQ_MASK, 32'h00000001);
        repeat (3) @(posedge hclk);
        check({31'h0, irq}, 32'h1, "unmasked event");
        ahb(1'b1, OFS_IRQ_STAT, 32'h00000001);
        repeat (3) @(posedge hclk);
        ahb(1'b0, OFS_IRQ_STAT, 32'h0);
        check({30'h0, irq, rd[0]}, 32'h0, "event cleared");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        check({28'h0, irq, term_out}, 32'h0, "outputs in second reset");
        hresetn <= 1'b1;
        rdchk(OFS_IRQ_MASK, 32'h0, "mask after second reset");
        end_sim();
    end

    task wr_all();
        ahb(1'b1, 8'h3C, 32'hFFFFFFFF);
        for (int a = 0; a < 16; a++) begin
            rdchk(8'(a * 4), 32'h0, "reset value");
        end
        ahb(1'b1, OFS_ZS_THR, {16'h0000, ZS_T});
        ahb(1'b1, OFS_DEV_LIM, {16'h0000, DEV_L});
        ahb(1'b1, OFS_OL2_THR, {16'h0000, OL_T});
        ahb(1'b1, OFS_VLOSS_THR, {16'h0000, VL_T});
        ahb(1'b1, OFS_ILOSS_THR, {16'h0000, IL_T});
        ahb(1'b1, OFS_FLAGS, 32'h0000FFFF);
        rdchk(OFS_DEV_LIM, {16'h0000, DEV_L}, "limit readback");
    endtask
endmodule
